// ===== logic/pscg_pkg.sv
// Constants for the power-saving clock gating block.
// Behaviour
// R1: Four registers decoded at offsets 0x00, 0x04, 0x08, 0x0c from a fixed base.
// R2: Control bit 0 written one stops processor clock; zero leaves it unchanged.
// R3: Stopped processor clock restarts on any enabled interrupt or hardware reset.
// R4: Serial ports bits 2-3, timers bits 4-6, parallel I/O bit 8.
// R5: Ones written to the set register turn those peripheral clocks on.
// R6: Ones written to the clear register turn those peripheral clocks off.
// R7: Each status bit reads one while its peripheral clock runs, else zero.
// R8: After reset the status register reads 0x17c.
// R9: Control, set and clear registers are write only with no readable state.
// R10: A disabled peripheral clock stops at once and resumes where it stopped.
// R11: Software disables a peripheral clock only after its operations have finished.
// R12: Processor clock runs after reset; clock bits match interrupt source numbers.
// R13: Write-only registers and unused status bits read zero; unused write bits ignored.
package pscg_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [31:0] PSCG_BASE_ADDR   = 32'hffff4000;
   localparam logic [3:0]  PSCG_CPU_CMD_OFF = 4'h0;
   localparam logic [3:0]  PSCG_SET_OFF     = 4'h4;
   localparam logic [3:0]  PSCG_CLR_OFF     = 4'h8;
   localparam logic [3:0]  PSCG_STATE_OFF   = 4'hc;
   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int          PSCG_CPU_STOP_BIT      = 0;
   localparam int          PSCG_NUM_CLK           = 6;
   localparam int          SERIAL_PORT_A_CLOCK_BIT = 2;
   localparam int          SERIAL_PORT_B_CLOCK_BIT = 3;
   localparam int          TIMER_CHANNEL_A_CLOCK_BIT = 4;
   localparam int          TIMER_CHANNEL_B_CLOCK_BIT = 5;
   localparam int          TIMER_CHANNEL_C_CLOCK_BIT = 6;
   localparam int          PARALLEL_IO_CLOCK_BIT  = 8;
   localparam logic [31:0] PSCG_CLK_MASK          = 32'h0000017c;
   localparam logic [31:0] PSCG_STATE_RESET       = 32'h0000017c;
   localparam logic [1:0]  PSCG_RESP_OKAY         = 2'h0;
   localparam logic [1:0]  PSCG_RESP_SLVERR       = 2'h2;
   // ----------------------------------------------------------------
   // Processor clock states
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      PSCG_CPU_RUN  = 1'b0,
      PSCG_CPU_IDLE = 1'b1
   } pscg_cpu_state_t;
endpackage

// ===== logic/pscg_clk_gate.sv
// Glitch-free clock gate with a latch-free enable register on the falling edge.
module pscg_clk_gate
(
   // Clock in
   input  wire logic clk_in,
   input  wire logic aresetn,
   // Enable and gated clock
   input  wire logic enable,
   output wire logic clk_out
);
   logic en_low_r;

   // Enable changes only while the clock is low, so the output never shows a runt pulse.
   always_ff @(negedge clk_in)
   begin
      if (!aresetn)
         en_low_r <= 1'b1;
      else
         en_low_r <= enable; // R10
   end

   assign clk_out = clk_in & en_low_r; // R10
endmodule

// ===== logic/pscg_top.sv
// Power-saving clock gating block with an AXI4-Lite register slave.
//
// Implementation choice: register access over AXI4-Lite.
module pscg_top
   import pscg_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output wire logic        s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output wire logic        s_axi_wready,
   // AXI4-Lite write response
   output wire logic [1:0]  s_axi_bresp,
   output wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output wire logic        s_axi_arready,
   // AXI4-Lite read data
   output wire logic [31:0] s_axi_rdata,
   output wire logic [1:0]  s_axi_rresp,
   output wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Wake-up from the interrupt controller
   input  wire logic        irq_wake,
   // Gated clocks
   output wire logic        cpu_clk,
   output wire logic        cpu_clk_en,
   output wire logic [8:0]  periph_clk,
   output wire logic [8:0]  periph_clk_en
);
   // ----------------------------------------------------------------
   // Write channel capture
   // ----------------------------------------------------------------
   logic [31:0]     awaddr_r;
   logic            aw_held_r;
   logic [31:0]     wdata_r;
   logic [3:0]      wstrb_r;
   logic            w_held_r;
   logic            bvalid_r;
   logic [1:0]      bresp_r;
   logic            wr_go;
   logic [3:0]      wr_off;
   logic            wr_hit;
   logic [31:0]     wr_mask;
   logic [31:0]     wr_bits;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign wr_go         = aw_held_r && w_held_r && !bvalid_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         awaddr_r  <= 32'h00000000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
      end
      else if (wr_go)
         aw_held_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r <= 1'b0;
         wdata_r  <= 32'h00000000;
         wstrb_r  <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end
      else if (wr_go)
         w_held_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // The upper twenty bits are compared to the base and bits 11:4 must be zero; the window is 16 bytes.
   assign wr_off = awaddr_r[3:0];
   assign wr_hit = (awaddr_r[31:12] == PSCG_BASE_ADDR[31:12]) && (awaddr_r[11:4] == 8'h00)
                   && (awaddr_r[1:0] == 2'h0); // R1
   assign wr_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign wr_bits = wdata_r & wr_mask;

   logic cpu_stop_wr;
   logic set_wr;
   logic clr_wr;

   assign cpu_stop_wr = wr_go && wr_hit && (wr_off == PSCG_CPU_CMD_OFF)
                        && wr_bits[PSCG_CPU_STOP_BIT]; // R2
   assign set_wr      = wr_go && wr_hit && (wr_off == PSCG_SET_OFF);
   assign clr_wr      = wr_go && wr_hit && (wr_off == PSCG_CLR_OFF);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= PSCG_RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
         // The status register is read only, so a write to it is refused.
         bresp_r  <= (wr_hit && (wr_off != PSCG_STATE_OFF)) ? PSCG_RESP_OKAY : PSCG_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;

   // ----------------------------------------------------------------
   // Peripheral clock enables
   // ----------------------------------------------------------------
   logic [31:0] clk_state_r;
   logic [31:0] set_bits;
   logic [31:0] clr_bits;

   // Unused positions are masked, so writes there never reach state.
   assign set_bits = set_wr ? (wr_bits & PSCG_CLK_MASK) : 32'h00000000; // R4 R13
   assign clr_bits = clr_wr ? (wr_bits & PSCG_CLK_MASK) : 32'h00000000; // R4 R13

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clk_state_r <= PSCG_STATE_RESET; // R8 R12
      else
         clk_state_r <= (clk_state_r | set_bits) & ~clr_bits; // R5 R6
   end

   // Software is expected to let a peripheral finish before stopping it; no check is made here.
   // R11

   // One gate per peripheral bit position; bit index equals interrupt source number.
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi = gi + 1)
      begin : g_periph
         if (PSCG_CLK_MASK[gi])
         begin : g_gate
            pscg_clk_gate u_gate
            (
               .clk_in  (aclk),
               .aresetn (aresetn),
               .enable  (clk_state_r[gi]), // R10 R12
               .clk_out (periph_clk[gi])
            );
         end
         else
         begin : g_none
            assign periph_clk[gi] = 1'b0;
         end
      end
   endgenerate

   assign periph_clk_en = clk_state_r[8:0]; // R7

   // ----------------------------------------------------------------
   // Processor clock state
   // ----------------------------------------------------------------
   pscg_cpu_state_t cpu_state_r;
   logic            wake_meta_r;
   logic            wake_sync_r;

   // The wake request may come from asynchronous sources, so it is synchronised.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_meta_r <= 1'b0;
         wake_sync_r <= 1'b0;
      end
      else
      begin
         wake_meta_r <= irq_wake;
         wake_sync_r <= wake_meta_r;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cpu_state_r <= PSCG_CPU_RUN; // R3 R12
      else
      begin
         case (cpu_state_r)
            PSCG_CPU_RUN:
               if (cpu_stop_wr)
                  cpu_state_r <= PSCG_CPU_IDLE; // R2
            PSCG_CPU_IDLE:
               if (wake_sync_r)
                  cpu_state_r <= PSCG_CPU_RUN; // R3
            default:
               cpu_state_r <= PSCG_CPU_RUN;
         endcase
      end
   end

   assign cpu_clk_en = (cpu_state_r == PSCG_CPU_RUN);

   pscg_clk_gate u_cpu_gate
   (
      .clk_in  (aclk),
      .aresetn (aresetn),
      .enable  (cpu_clk_en),
      .clk_out (cpu_clk)
   );

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        rd_hit;

   assign s_axi_arready = !rvalid_r;
   assign rd_hit = (s_axi_araddr[31:12] == PSCG_BASE_ADDR[31:12])
                   && (s_axi_araddr[11:4] == 8'h00) && (s_axi_araddr[1:0] == 2'h0); // R1

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h00000000;
         rresp_r  <= PSCG_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= rd_hit ? PSCG_RESP_OKAY : PSCG_RESP_SLVERR;
         if (rd_hit && (s_axi_araddr[3:0] == PSCG_STATE_OFF))
            rdata_r <= clk_state_r & PSCG_CLK_MASK; // R7 R13
         else
            rdata_r <= 32'h00000000; // R9 R13
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;
endmodule

// ===== verif/pscg_checker.sv
// Port-level assertions for the clock gating block.
module pscg_checker
   import pscg_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Clock control
   input wire logic        irq_wake,
   input wire logic        cpu_clk_en,
   input wire logic [8:0]  periph_clk_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   AST_UNUSED_BITS: assert property ((periph_clk_en & ~PSCG_CLK_MASK[8:0]) == 9'h000)
      else $error("unused clock bit set");
   AST_PERIPH_ON_WRITE: assert property ($changed(periph_clk_en) |-> $rose(s_axi_bvalid))
      else $error("peripheral enable moved without a write");
   AST_STOP_ON_WRITE: assert property ($fell(cpu_clk_en) |-> $rose(s_axi_bvalid))
      else $error("processor clock stopped without a write");
   AST_WAKE: assert property ($rose(irq_wake) && !cpu_clk_en |-> ##[1:3] cpu_clk_en)
      else $error("processor clock not woken");
   AST_IDLE_HOLDS: assert property (!cpu_clk_en && !irq_wake && !$past(irq_wake) &&
      !$past(irq_wake, 2) |=> !cpu_clk_en) else $error("idle left without wake");
   cover property ($fell(cpu_clk_en));
   cover property ($rose(cpu_clk_en));
   cover property (s_axi_bvalid && s_axi_bresp == PSCG_RESP_SLVERR);
   cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind pscg_top pscg_checker pscg_checker_i
(
   .aclk          (aclk),
   .aresetn       (aresetn),
   .s_axi_bresp   (s_axi_bresp),
   .s_axi_bvalid  (s_axi_bvalid),
   .s_axi_bready  (s_axi_bready),
   .s_axi_arvalid (s_axi_arvalid),
   .s_axi_arready (s_axi_arready),
   .s_axi_rdata   (s_axi_rdata),
   .s_axi_rvalid  (s_axi_rvalid),
   .s_axi_rready  (s_axi_rready),
   .irq_wake      (irq_wake),
   .cpu_clk_en    (cpu_clk_en),
   .periph_clk_en (periph_clk_en)
);

// ===== verif/pscg_tb.sv
// Self-checking bench for the clock gating block.
module tb
   import pscg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, irq_wake, cpu_clk, cpu_clk_en;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, ex;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [8:0]  periph_clk, periph_clk_en;
   int          num_errors, cmp_count, cycles, ready_lag;
   localparam logic [31:0] B   = PSCG_BASE_ADDR;
   localparam logic [1:0]  OK  = PSCG_RESP_OKAY;
   localparam logic [1:0]  ERR = PSCG_RESP_SLVERR;
   pscg_top pscg_top_i
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .irq_wake      (irq_wake),
      .cpu_clk       (cpu_clk),
      .cpu_clk_en    (cpu_clk_en),
      .periph_clk    (periph_clk),
      .periph_clk_en (periph_clk_en)
   );
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Ready is looked at mid-cycle, where it already shows what the next edge samples.
   // A nonzero ready_lag holds bready or rready low for that many edges first.
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      logic       aw, w, b;
      logic [1:0] r;
      int         n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= (ready_lag == 0);
      n = 0;
      do
      begin
         @(negedge aclk);
         aw = s_axi_awready;
         w = s_axi_wready;
         b = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         n++;
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (n >= ready_lag && b !== 1'b1) s_axi_bready <= 1'b1;
      end
      while (b !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic        ar, v;
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= (ready_lag == 0);
      n = 0;
      do
      begin
         @(negedge aclk);
         ar = s_axi_arready;
         v = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         n++;
         if (ar) s_axi_arvalid <= 1'b0;
         if (n >= ready_lag && v !== 1'b1) s_axi_rready <= 1'b1;
      end
      while (v !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic t_reset();
      rd(B + 32'hc, 32'h17c, OK);
      chk({23'h0, periph_clk_en}, 32'h17c);
      chk({31'h0, cpu_clk_en}, 32'h1);
      rd(B, 32'h0, OK);
      rd(B + 32'h4, 32'h0, OK);
      rd(B + 32'h8, 32'h0, OK);
      rd(B + 32'h10, 32'h0, ERR);
      wr(B + 32'h18, 32'hffffffff, ERR);
      chk({23'h0, periph_clk_en}, 32'h17c);
      wr(B + 32'hc, 32'h0, ERR);
   endtask
   task automatic t_periph();
      int bits [6] = '{2, 3, 4, 5, 6, 8};
      wr(B + 32'h8, 32'hffffffff, OK);
      wr(B + 32'h4, 32'hfffffe83, OK);
      rd(B + 32'hc, 32'h0, OK);
      @(posedge aclk);
      #10;
      chk({23'h0, periph_clk}, 32'h0);
      ex = 32'h0;
      foreach (bits[i])
      begin
         ex[bits[i]] = 1'b1;
         wr(B + 32'h4, 32'h1 << bits[i], OK);
         rd(B + 32'hc, ex, OK);
      end
      @(posedge aclk);
      #10;
      chk({23'h0, periph_clk}, 32'h17c);
      foreach (bits[i])
      begin
         ex[bits[i]] = 1'b0;
         wr(B + 32'h8, 32'h1 << bits[i], OK);
         chk({23'h0, periph_clk_en}, ex);
      end
   endtask
   task automatic t_lag();
      ready_lag = 3;
      s_axi_wstrb <= 4'h2;
      wr(B + 32'h4, 32'h17c, OK);
      s_axi_wstrb <= 4'hf;
      rd(B + 32'hc, 32'h100, OK);
      wr(B + 32'h8, 32'h100, OK);
      rd(B + 32'hc, 32'h0, OK);
      ready_lag = 0;
   endtask
   task automatic t_cpu();
      wr(B, 32'hfffffffe, OK);
      chk({31'h0, cpu_clk_en}, 32'h1);
      wr(B, 32'h1, OK);
      chk({31'h0, cpu_clk_en}, 32'h0);
      @(posedge aclk);
      #10;
      chk({31'h0, cpu_clk}, 32'h0);
      rd(B + 32'hc, 32'h0, OK);
      irq_wake <= 1'b1;
      repeat (3) @(posedge aclk);
      irq_wake <= 1'b0;
      @(negedge aclk);
      chk({31'h0, cpu_clk_en}, 32'h1);
   endtask
   task automatic t_rst();
      wr(B, 32'h1, OK);
      chk({31'h0, cpu_clk_en}, 32'h0);
      wr(B + 32'h4, 32'h14, OK);
      chk({23'h0, periph_clk_en}, 32'h14);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk({31'h0, cpu_clk_en}, 32'h1);
      rd(B + 32'hc, 32'h17c, OK);
   endtask
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   initial
   begin
      aresetn = 1'b0;
      irq_wake = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = 32'h0;
      s_axi_wdata = 32'h0;
      s_axi_araddr = 32'h0;
      s_axi_wstrb = 4'hf;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_periph();
      t_lag();
      t_cpu();
      t_rst();
      tally_and_finish();
   end
endmodule
